/* verilog/twsx_pkg.sv */
// shared types and constants for the table-write / test-skip / xor executor
package twsx_pkg;
  localparam int TWSX_PTR_W = 21;
  localparam int TWSX_HOLD_N = 8;
  localparam int TWSX_HOLD_AW = 3;
  localparam int TWSX_ADDR_W = 12;

  // opcode patterns
  localparam logic [13:0] TWSX_OP_TABLE_WRITE_OP = 14'h0003;
  localparam logic [6:0] TWSX_OP_TEST_REG_SKIP_IF_NULL = 7'h33;
  localparam logic [7:0] TWSX_OP_XOR_LITERAL_ACCUM = 8'h0A;
  localparam logic [7:0] TWSX_IDX_MAX = 8'h5F;

  // instruction word field positions
  localparam int TWSX_MODE_LSB = 0;
  localparam int TWSX_ABIT = 8;
  localparam int TWSX_TBL_OP_LSB = 2;
  localparam int TWSX_TST_OP_LSB = 9;
  localparam int TWSX_XOR_OP_LSB = 8;

  // table pointer update modes
  localparam logic [1:0] TWSX_TW_KEEP = 2'h0;
  localparam logic [1:0] TWSX_TW_POSTINC = 2'h1;
  localparam logic [1:0] TWSX_TW_POSTDEC = 2'h2;
  localparam logic [1:0] TWSX_TW_PREINC = 2'h3;

  // extra busy cycles after the accepting cycle
  localparam logic [1:0] TWSX_XTRA_NONE = 2'h0;
  localparam logic [1:0] TWSX_XTRA_ONE = 2'h1;
  localparam logic [1:0] TWSX_XTRA_TWO = 2'h2;

  localparam logic [TWSX_PTR_W-1:0] TWSX_PTR_ONE = 21'h000001;
  localparam logic [TWSX_PTR_W-1:0] TWSX_PTR_RST = 21'h000000;
  localparam logic [7:0] TWSX_ACC_RST = 8'h00;
  localparam logic [7:0] TWSX_BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    TWSX_AM_ACCESS,
    TWSX_AM_BANKED,
    TWSX_AM_INDEXED
  } twsx_amode_t;

  typedef enum {
    TWSX_ST_READY,
    TWSX_ST_BUSY
  } twsx_st_t;

  typedef struct packed {
    logic en;
    logic [TWSX_HOLD_AW-1:0] addr;
    logic [7:0] data;
  } twsx_hwr_t;

  typedef struct packed {
    twsx_amode_t mode;
    logic [TWSX_ADDR_W-1:0] addr;
  } twsx_fsel_t;

  typedef struct packed {
    logic neg;
    logic zero;
  } twsx_flags_t;
endpackage : twsx_pkg

/* verilog/twsx_hold_mem.sv */
// eight-byte holding register file with registered read port
module twsx_hold_mem
  import twsx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input twsx_hwr_t wr,
  input wire logic [TWSX_HOLD_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  typedef struct packed {
    logic [TWSX_HOLD_N-1:0][7:0] mem;
    logic [7:0] rdat;
  } twsx_mem_st_t;

  twsx_mem_st_t st_ff;
  twsx_mem_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (wr.en)
    begin
      nxt_st.mem[wr.addr] = wr.data;
    end
    nxt_st.rdat = st_ff.mem[rd_addr];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rdat;
endmodule : twsx_hold_mem

/* verilog/twsx_core.sv */
// executor for table write, test-and-skip-if-zero and xor-literal
module twsx_core
  import twsx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic next_two_word,
  input wire logic [7:0] file_rd_data,
  input wire logic ext_enable,
  input wire logic [3:0] bank_pointer_reg,
  input wire logic [TWSX_ADDR_W-1:0] index_base,
  input wire logic [7:0] table_latch,
  input wire logic tptr_load,
  input wire logic [TWSX_PTR_W-1:0] tptr_load_val,
  input wire logic accum_load,
  input wire logic [7:0] accum_load_val,
  input wire logic [TWSX_HOLD_AW-1:0] hold_rd_addr,
  output logic ready,
  output logic [TWSX_PTR_W-1:0] table_pointer,
  output logic [7:0] accum,
  output twsx_flags_t flags,
  output logic skip_pulse,
  output twsx_fsel_t file_sel,
  output logic hold_wr_pulse,
  output logic [TWSX_HOLD_AW-1:0] hold_wr_idx,
  output logic hold_hi_byte,
  output logic [7:0] hold_rd_data
);
  typedef struct packed {
    twsx_st_t st;
    logic [1:0] xtra;
    logic ready;
    logic [TWSX_PTR_W-1:0] tptr;
    logic [7:0] accum;
    twsx_flags_t flags;
    logic skip;
    twsx_fsel_t fsel;
    logic tw_pend;
    twsx_hwr_t hwr;
    logic hi_byte;
  } twsx_core_st_t;

  twsx_core_st_t st_ff;
  twsx_core_st_t nxt_st;

  logic take;
  logic is_table_write_op;
  logic is_tst;
  logic is_xor;
  logic [1:0] tw_mode;
  logic [7:0] fld;
  logic abit;
  logic [TWSX_PTR_W-1:0] tw_addr;
  logic [7:0] xres;

  // offers made while busy are simply not taken
  assign take = instr_valid && st_ff.ready;
  assign is_table_write_op =
    (instr_word[15:TWSX_TBL_OP_LSB] == TWSX_OP_TABLE_WRITE_OP);
  assign is_tst =
    (instr_word[15:TWSX_TST_OP_LSB] == TWSX_OP_TEST_REG_SKIP_IF_NULL);
  assign is_xor =
    (instr_word[15:TWSX_XOR_OP_LSB] == TWSX_OP_XOR_LITERAL_ACCUM);
  assign tw_mode = instr_word[TWSX_MODE_LSB +: 2];
  assign fld = instr_word[7:0];
  assign abit = instr_word[TWSX_ABIT];
  // pre-increment writes through the already advanced pointer
  assign tw_addr = (tw_mode == TWSX_TW_PREINC) ?
    st_ff.tptr + TWSX_PTR_ONE : st_ff.tptr;
  assign xres = st_ff.accum ^ fld;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.skip = 1'b0;
    nxt_st.hwr.en = 1'b0;
    if (tptr_load)
    begin
      nxt_st.tptr = tptr_load_val;
    end
    if (accum_load)
    begin
      nxt_st.accum = accum_load_val;
    end
    case (st_ff.st)
      TWSX_ST_READY:
      begin
        if (take && is_table_write_op)
        begin
          // byte captured now, write pulse raised in the third cycle, on the same edge that ready returns
          nxt_st.hwr.addr = tw_addr[TWSX_HOLD_AW-1:0];
          nxt_st.hwr.data = table_latch;
          nxt_st.hi_byte = tw_addr[0];
          nxt_st.tw_pend = 1'b1;
          // pointer update wins over a same-edge pointer load
          case (tw_mode)
            TWSX_TW_KEEP: nxt_st.tptr = st_ff.tptr;
            TWSX_TW_POSTINC: nxt_st.tptr = st_ff.tptr + TWSX_PTR_ONE;
            TWSX_TW_POSTDEC: nxt_st.tptr = st_ff.tptr - TWSX_PTR_ONE;
            TWSX_TW_PREINC: nxt_st.tptr = st_ff.tptr + TWSX_PTR_ONE;
            default: nxt_st.tptr = st_ff.tptr;
          endcase
          nxt_st.xtra = TWSX_XTRA_ONE;
          nxt_st.ready = 1'b0;
          nxt_st.st = TWSX_ST_BUSY;
        end
        else if (take && is_tst)
        begin
          if (!abit && ext_enable && fld <= TWSX_IDX_MAX)
          begin
            nxt_st.fsel.mode = TWSX_AM_INDEXED;
            nxt_st.fsel.addr = index_base + {4'h0, fld};
          end
          else if (!abit)
          begin
            nxt_st.fsel.mode = TWSX_AM_ACCESS;
            nxt_st.fsel.addr = {4'h0, fld};
          end
          else
          begin
            // bank pointer supplies the upper address nibble
            nxt_st.fsel.mode = TWSX_AM_BANKED;
            nxt_st.fsel.addr = {bank_pointer_reg, fld};
          end
          // flags deliberately untouched on both outcomes
          if (file_rd_data == TWSX_BYTE_ZERO)
          begin
            nxt_st.skip = 1'b1;
            nxt_st.xtra = next_two_word ?
              TWSX_XTRA_TWO : TWSX_XTRA_ONE;
            nxt_st.ready = 1'b0;
            nxt_st.st = TWSX_ST_BUSY;
          end
        end
        else if (take && is_xor)
        begin
          // load port loses to the instruction's own writeback
          nxt_st.accum = xres;
          nxt_st.flags.neg = xres[7];
          nxt_st.flags.zero = (xres == TWSX_BYTE_ZERO);
        end
        // any other word is taken and leaves all state alone
      end
      TWSX_ST_BUSY:
      begin
        if (st_ff.tw_pend)
        begin
          nxt_st.hwr.en = 1'b1;
          nxt_st.tw_pend = 1'b0;
        end
        // count down the extra cycles still owed
        nxt_st.xtra = st_ff.xtra - TWSX_XTRA_ONE;
        if (st_ff.xtra == TWSX_XTRA_ONE)
        begin
          nxt_st.ready = 1'b1;
          nxt_st.st = TWSX_ST_READY;
        end
      end
      default:
      begin
        nxt_st.st = TWSX_ST_READY;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= '{
        st: TWSX_ST_READY,
        xtra: TWSX_XTRA_NONE,
        ready: 1'b1,
        tptr: TWSX_PTR_RST,
        accum: TWSX_ACC_RST,
        flags: '0,
        skip: 1'b0,
        fsel: '{mode: TWSX_AM_ACCESS, addr: '0},
        tw_pend: 1'b0,
        hwr: '0,
        hi_byte: 1'b0
      };
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // read port runs apart from writes, one cycle behind its address
  twsx_hold_mem u_hold
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr(st_ff.hwr),
    .rd_addr(hold_rd_addr),
    .rd_data(hold_rd_data)
  );

  assign ready = st_ff.ready;
  assign table_pointer = st_ff.tptr;
  assign accum = st_ff.accum;
  assign flags = st_ff.flags;
  assign skip_pulse = st_ff.skip;
  assign file_sel = st_ff.fsel;
  assign hold_wr_pulse = st_ff.hwr.en;
  assign hold_wr_idx = st_ff.hwr.addr;
  assign hold_hi_byte = st_ff.hi_byte;
endmodule : twsx_core

/* tb/twsx_hold_model.sv */
// behavioural holding-register store, read-back reference
module twsx_hold_model
  import twsx_pkg::*;
(
  input wire logic clk_sys,
  input twsx_hwr_t wr,
  input wire logic [TWSX_HOLD_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_ff [TWSX_HOLD_N];
  always @(posedge clk_sys)
  begin
    if (wr.en)
      mem_ff[wr.addr] <= wr.data;
    rd_data <= mem_ff[rd_addr];
  end
endmodule : twsx_hold_model

/* tb/twsx_core_asserts.sv */
// assertions on the executor ports
module twsx_core_asserts
  import twsx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic next_two_word,
  input wire logic [7:0] file_rd_data,
  input wire logic ready,
  input wire logic [TWSX_PTR_W-1:0] table_pointer,
  input wire logic [7:0] accum,
  input twsx_flags_t flags,
  input wire logic skip_pulse,
  input wire logic [TWSX_HOLD_AW-1:0] hold_wr_idx,
  input wire logic hold_hi_byte
);
  wire logic tk = instr_valid && ready;
  wire logic tw = tk && instr_word[15:2] == TWSX_OP_TABLE_WRITE_OP;
  wire logic ts = tk && instr_word[15:9] == TWSX_OP_TEST_REG_SKIP_IF_NULL;
  wire logic xo = tk && instr_word[15:8] == TWSX_OP_XOR_LITERAL_ACCUM;
  wire logic z = file_rd_data == 8'h00;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  tw_busy_a: assert property (tw |=> !ready ##1 ready)
    else $error("table write span wrong");
  tw_index_a: assert property (tw && instr_word[1:0] != 2'h3 |=>
    {hold_wr_idx, hold_hi_byte} == $past({table_pointer[2:0],
    table_pointer[0]})) else $error("holding index wrong");
  tw_dec_a: assert property (tw && instr_word[1:0] == 2'h2 |=>
    table_pointer == $past(table_pointer) - TWSX_PTR_ONE)
    else $error("pointer decrement wrong");
  skip_zero_a: assert property (ts && z |=> skip_pulse && !ready)
    else $error("skip not taken");
  skip_three_a: assert property (ts && z && next_two_word |=>
    !ready [*2] ##1 ready) else $error("two-word skip span wrong");
  tw_preinc_a: assert property (tw && instr_word[1:0] == 2'h3 |=>
    {hold_wr_idx, hold_hi_byte} == $past({table_pointer[2:0] + 3'h1,
    table_pointer[0] ^ 1'b1})) else $error("pre-increment index wrong");
  flags_keep_a: assert property (ts || tw |=> $stable(flags))
    else $error("flags changed");
  xor_acc_a: assert property (xo |=> accum ==
    ($past(accum) ^ $past(instr_word[7:0]))) else $error("xor wrong");
  xor_flags_a: assert property (xo |=>
    flags == {accum[7], accum == 8'h00}) else $error("xor flags wrong");
endmodule : twsx_core_asserts
bind twsx_core twsx_core_asserts i_twsx_core_asserts (.clk_sys(clk_sys),
  .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
  .next_two_word(next_two_word), .file_rd_data(file_rd_data),
  .ready(ready), .table_pointer(table_pointer), .accum(accum),
  .flags(flags), .skip_pulse(skip_pulse), .hold_wr_idx(hold_wr_idx),
  .hold_hi_byte(hold_hi_byte));

/* tb/twsx_core_test.sv */
// self-checking bench for the executor
module twsx_core_test
  import twsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_n = 0, instr_valid = 0, next_two_word = 0;
  logic ext_enable = 0, tptr_load = 0, accum_load = 0;
  logic [15:0] instr_word = '0;
  logic [7:0] file_rd_data = '0, table_latch = '0, accum_load_val = '0;
  logic [3:0] bank_pointer_reg = '0;
  logic [TWSX_ADDR_W-1:0] index_base = '0;
  logic [TWSX_PTR_W-1:0] tptr_load_val = '0, table_pointer;
  logic [TWSX_HOLD_AW-1:0] hold_rd_addr = '0, hold_wr_idx;
  logic ready, skip_pulse, hold_wr_pulse, hold_hi_byte;
  logic [7:0] accum, hold_rd_data, m_rd;
  twsx_flags_t flags;
  twsx_fsel_t file_sel;
  twsx_hwr_t mwr = '0;
  logic [11:0] exp_q [$];
  logic [11:0] e;
  logic [31:0] seed = 32'h69A7B8A1, p, q, r;
  int errors = 0, comparisons = 0, n;
  always #5 clk_sys = ~clk_sys;
  twsx_core i_twsx_core (.clk_sys(clk_sys), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .next_two_word(next_two_word), .file_rd_data(file_rd_data),
    .ext_enable(ext_enable), .bank_pointer_reg(bank_pointer_reg),
    .index_base(index_base), .table_latch(table_latch),
    .tptr_load(tptr_load), .tptr_load_val(tptr_load_val),
    .accum_load(accum_load), .accum_load_val(accum_load_val),
    .hold_rd_addr(hold_rd_addr), .ready(ready),
    .table_pointer(table_pointer), .accum(accum), .flags(flags),
    .skip_pulse(skip_pulse), .file_sel(file_sel),
    .hold_wr_pulse(hold_wr_pulse), .hold_wr_idx(hold_wr_idx),
    .hold_hi_byte(hold_hi_byte), .hold_rd_data(hold_rd_data));
  twsx_hold_model i_twsx_hold_model (.clk_sys(clk_sys), .wr(mwr),
    .rd_addr(hold_rd_addr), .rd_data(m_rd));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick
  task issue(input logic [15:0] w);
    instr_word = w;
    instr_valid = 1'b1;
    tick(1);
    instr_valid = 1'b0;
  endtask : issue
  task final_report;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // oldest noted holding write against each write pulse
  always @(posedge clk_sys)
  begin
    e = hold_wr_pulse ? exp_q.pop_front() : 12'h000;
    if (hold_wr_pulse)
      check({hold_hi_byte, hold_wr_idx}, e[11:8]);
    mwr <= {hold_wr_pulse, e[10:0]};
  end
  initial
  begin
    #20000;
    errors++;
    final_report;
  end
  initial
  begin
    tick(3);
    rst_n = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      q = $random(seed);
      p = q & 32'h1FFFFF;
      table_latch = q[31:24];
      tptr_load_val = p[20:0];
      tptr_load = 1'b1;
      tick(1);
      tptr_load = 1'b0;
      q = (m == 3) ? p + 1 : p;
      exp_q.push_back({q[0], q[2:0], table_latch});
      issue({TWSX_OP_TABLE_WRITE_OP, m[1:0]});
      check(ready, 0);
      check(table_pointer,
        (m == 0 ? p : m == 2 ? p - 1 : p + 1) & 32'h1FFFFF);
      tick(3);
      hold_rd_addr = q[2:0];
      tick(3);
      check(hold_rd_data, m_rd);
    end
    $display("table write test done");
    for (int i = 0; i < 16; i++)
    begin
      q = $random(seed);
      {bank_pointer_reg, index_base} = q[15:0];
      next_two_word = i[2];
      ext_enable = i[1];
      // 5F is the last offset that still goes indexed
      p[7:0] = i[2] ? 8'h90 : 8'h5F;
      file_rd_data = i[3] ? 8'h00 : q[23:16] | 8'h01;
      r = i[0] ? {TWSX_AM_BANKED, bank_pointer_reg, p[7:0]}
        : (i[1] && !i[2]) ? {TWSX_AM_INDEXED, index_base + p[7:0]}
        : {TWSX_AM_ACCESS, 4'h0, p[7:0]};
      issue({TWSX_OP_TEST_REG_SKIP_IF_NULL, i[0], p[7:0]});
      check(skip_pulse, i[3]);
      check(file_sel, r);
      n = 0;
      while (ready !== 1'b1 && n < 8)
      begin
        tick(1);
        n++;
      end
      check(n, i[3] ? 1 + next_two_word : 0);
      // idle edge so the next offer is a fresh request
      tick(1);
    end
    $display("test skip test done");
    for (int i = 0; i < 8; i++)
    begin
      q = $random(seed);
      accum_load_val = q[7:0];
      accum_load = 1'b1;
      tick(1);
      // one same-edge load, which the xor must override
      accum_load = (i == 1);
      p[7:0] = (i == 0) ? q[7:0] : q[15:8];
      r = q[7:0] ^ p[7:0];
      issue({TWSX_OP_XOR_LITERAL_ACCUM, p[7:0]});
      check(accum, r);
      check(flags, {r[7], r[7:0] == 8'h00});
    end
    $display("xor test done");
    check(exp_q.size(), 0);
    final_report;
  end
endmodule : twsx_core_test
